// *** stpic_defs.svh ***
`ifndef STPIC_DEFS_SVH
`define STPIC_DEFS_SVH

// Register byte offsets
`define STPIC_OFF_STATUS 8'h00
`define STPIC_OFF_MASK 8'h04
`define STPIC_OFF_CTRL 8'h08
`define STPIC_OFF_STATE 8'h0c

// Reset values
`define STPIC_RST_MASK 12'h000
`define STPIC_RST_CTRL 4'h0

// Status layout: parity events, BIST passes, align errors, one bit per channel
`define STPIC_ST_PAR_LSB 0
`define STPIC_ST_BIST_LSB 4
`define STPIC_ST_ALIGN_LSB 8

// Character sent in place of a character with bad parity
`define STPIC_BAD_CHAR 10'h278

// BIST sequence length in characters, and last count of a pass
`define STPIC_BIST_LEN 511
`define STPIC_BIST_LAST 9'h1fe

// Phase-align buffer occupancy: empty, centre, full
`define STPIC_LVL_EMPTY 2'h0
`define STPIC_LVL_CENTRE 2'h1
`define STPIC_LVL_FULL 2'h2

`endif

// *** stpic_pkg.sv ***
package stpic_pkg;
  // Three-level static select as seen after level conversion
  typedef enum logic [1:0] {
    STPIC_SEL_LOW = 2'b00,
    STPIC_SEL_MID = 2'b01,
    STPIC_SEL_HIGH = 2'b10
  } stpic_sel_t;
endpackage

// *** stpic_sync.sv ***
module stpic_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [2:0] fill_r;

  // First stage is read only by the second stage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      fill_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end

  // Edges wait until the last stage holds a real pin sample, so a pin
  // that is high at reset release does not fake an edge
  assign sync_out = sync_r;
  assign rise = sync_r & ~prev_r & {W{fill_r[2]}};
  assign fall = ~sync_r & prev_r & {W{fill_r[2]}};
endmodule

// *** stpic_clkgen.sv ***
module stpic_clkgen #(
  parameter int CW = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ref_rise,
  input wire logic ref_fall,
  input wire logic rate_high,
  output logic char_tick,
  output logic clk_out,
  output logic clk_out_n
);
  logic tick_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] half_r;
  logic char_tick_r;
  logic clk_r;
  logic clk_n_r;

  // Half-rate reference: both reference edges make a character time
  assign tick_nxt = ref_rise | (rate_high & ref_fall);

  // Output is high for half of the last measured character period
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= '0;
      half_r <= '0;
      char_tick_r <= 1'b0;
      clk_r <= 1'b0;
      clk_n_r <= 1'b1;
    end else begin
      char_tick_r <= tick_nxt;
      if (tick_nxt) begin
        cnt_r <= '0;
        half_r <= cnt_r >> 1;
        clk_r <= 1'b1;
        clk_n_r <= 1'b0;
      end else begin
        if (cnt_r != '1) cnt_r <= cnt_r + 1'b1;
        if (cnt_r >= half_r) begin
          clk_r <= 1'b0;
          clk_n_r <= 1'b1;
        end
      end
    end
  end

  assign char_tick = char_tick_r;
  assign clk_out = clk_r;
  assign clk_out_n = clk_n_r;
endmodule

// *** stpic_top.sv ***
`include "stpic_defs.svh"

module stpic_top #(
  parameter int NCH = 4,
  parameter int CW = 10
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic reference_clock_in,
  input wire logic [NCH-1:0] tx_channel_input_clock,
  input wire logic [NCH-1:0][CW-1:0] tx_char_in,
  input wire logic [NCH-1:0] tx_odd_parity_in,
  input wire stpic_pkg::stpic_sel_t parity_control,
  input wire stpic_pkg::stpic_sel_t tx_input_clock_select,
  input wire logic tx_rate_select,
  input wire logic tx_align_reset_n,
  input wire logic [NCH-1:0] tx_word_sync_in,
  output logic [NCH-1:0][CW-1:0] tx_char_out,
  output logic tx_char_valid,
  output logic [NCH-1:0] tx_error_flag,
  output logic tx_phase_align_en,
  output logic tx_char_clock_out,
  output logic tx_char_clock_out_n,
  output logic irq
);
  import stpic_pkg::*;

  localparam int SW = 1 + NCH + NCH * CW + NCH + 2 + 2 + 1 + 1 + NCH;

  logic [SW-1:0] pin_async;
  logic [SW-1:0] pin_sync;
  logic [SW-1:0] pin_rise;
  logic [SW-1:0] pin_fall;
  logic ref_s;
  logic ref_rise;
  logic ref_fall;
  logic [NCH-1:0] chclk_rise;
  logic [NCH-1:0][CW-1:0] data_s;
  logic [NCH-1:0] par_s;
  stpic_sel_t pctl_s;
  stpic_sel_t csel_s;
  logic rate_s;
  logic arst_n_s;
  logic [NCH-1:0] wsync_s;

  // All pins share one synchroniser so data and clock edges keep their alignment
  assign pin_async = {tx_word_sync_in, tx_align_reset_n, tx_rate_select,
                      2'(tx_input_clock_select), 2'(parity_control), tx_odd_parity_in,
                      tx_char_in, tx_channel_input_clock, reference_clock_in};

  stpic_sync #(.W(SW)) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(pin_async),
    .sync_out(pin_sync),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign ref_s = pin_sync[0];
  assign ref_rise = pin_rise[0];
  assign ref_fall = pin_fall[0];
  assign chclk_rise = pin_rise[NCH:1];
  assign data_s = pin_sync[NCH+NCH*CW:NCH+1];
  assign par_s = pin_sync[2*NCH+NCH*CW:NCH+NCH*CW+1];
  assign pctl_s = stpic_sel_t'(pin_sync[2*NCH+NCH*CW+2:2*NCH+NCH*CW+1]);
  assign csel_s = stpic_sel_t'(pin_sync[2*NCH+NCH*CW+4:2*NCH+NCH*CW+3]);
  assign rate_s = pin_sync[2*NCH+NCH*CW+5];
  assign arst_n_s = pin_sync[2*NCH+NCH*CW+6];
  assign wsync_s = pin_sync[SW-1:SW-NCH];

  // Character clock and its true and complement output
  logic char_tick;
  stpic_clkgen #(.CW(8)) u_clkgen (
    .core_clk(core_clk),
    .reset(reset),
    .ref_rise(ref_rise),
    .ref_fall(ref_fall),
    .rate_high(rate_s),
    .char_tick(char_tick),
    .clk_out(tx_char_clock_out),
    .clk_out_n(tx_char_clock_out_n)
  );

  // Static modes
  logic par_en;
  logic pa_en;
  logic ref_cap;
  assign par_en = (pctl_s != STPIC_SEL_LOW);
  assign pa_en = (csel_s != STPIC_SEL_LOW) || rate_s;
  assign ref_cap = ref_rise | (rate_s & ref_fall);

  // Registers
  logic [11:0] status_r;
  logic [11:0] mask_r;
  logic [NCH-1:0] ctrl_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic pa_en_r;
  logic wr_status;
  logic wr_mask;
  logic wr_ctrl;
  logic [11:0] ev_set;
  logic [11:0] status_nxt;
  logic [31:0] rdata_nxt;

  // Per-channel state
  logic [NCH-1:0] cap_stb;
  logic [NCH-1:0][CW-1:0] in_reg_r;
  logic [NCH-1:0] in_par_r;
  logic [NCH-1:0] par_bad;
  logic [NCH-1:0][CW-1:0] out_r;
  logic [NCH-1:0][8:0] bist_cnt_r;
  logic [NCH-1:0] bist_pass;
  logic [NCH-1:0][1:0] lvl_r;
  logic [NCH-1:0] under;
  logic [NCH-1:0] over;
  logic [NCH-1:0] aerr_r;
  logic [NCH-1:0] aerr_nxt;
  logic [NCH-1:0] perr_r;
  logic [NCH-1:0] perr_nxt;
  logic [NCH-1:0] bist_r;
  logic [NCH-1:0] bist_nxt;
  logic [NCH-1:0] flag_r;
  logic valid_r;

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      assign cap_stb[i] = (csel_s == STPIC_SEL_LOW) ? ref_cap :
                          (csel_s == STPIC_SEL_HIGH) ? chclk_rise[0] :
                          chclk_rise[i];
      // odd parity good when XOR is one
      assign par_bad[i] = par_en && char_tick && !(^{in_reg_r[i], in_par_r[i]});
      assign bist_pass[i] = ctrl_r[i] && char_tick &&
                            (bist_cnt_r[i] == `STPIC_BIST_LAST);
      assign under[i] = pa_en && char_tick && !cap_stb[i] &&
                        (lvl_r[i] == `STPIC_LVL_EMPTY);
      assign over[i] = pa_en && cap_stb[i] && !char_tick &&
                       (lvl_r[i] == `STPIC_LVL_FULL);
      // sticky until word sync or align reset
      // A new fault in the clearing cycle wins, so it is never lost
      assign aerr_nxt[i] = under[i] || over[i] ||
                           (aerr_r[i] && arst_n_s && !wsync_s[i]);
      // flag held for one character time
      assign perr_nxt[i] = char_tick ? par_bad[i] : perr_r[i];
      // pass pulse for one character time
      assign bist_nxt[i] = char_tick ? bist_pass[i] : bist_r[i];

      always_ff @(posedge core_clk) begin
        if (reset) begin
          in_reg_r[i] <= '0;
          in_par_r[i] <= 1'b1;
        end else if (cap_stb[i]) begin
          in_reg_r[i] <= data_s[i];
          in_par_r[i] <= par_s[i];
        end
      end

      always_ff @(posedge core_clk) begin
        if (reset) begin
          out_r[i] <= '0;
        end else if (char_tick) begin
          out_r[i] <= par_bad[i] ? `STPIC_BAD_CHAR : in_reg_r[i];
        end
      end

      // Counts character times while BIST runs; restarts when disabled
      always_ff @(posedge core_clk) begin
        if (reset || !ctrl_r[i]) begin
          bist_cnt_r[i] <= '0;
        end else if (char_tick) begin
          bist_cnt_r[i] <= bist_pass[i] ? 9'h000 : bist_cnt_r[i] + 9'h001;
        end
      end

      // Occupancy model of the phase-align buffer, re-centred by align reset
      always_ff @(posedge core_clk) begin
        if (reset || !arst_n_s || !pa_en) begin
          lvl_r[i] <= `STPIC_LVL_CENTRE;
        end else if (cap_stb[i] && !char_tick && !over[i]) begin
          lvl_r[i] <= lvl_r[i] + 2'h1;
        end else if (char_tick && !cap_stb[i] && !under[i]) begin
          lvl_r[i] <= lvl_r[i] - 2'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      aerr_r <= '0;
      perr_r <= '0;
      bist_r <= '0;
      flag_r <= '0;
      valid_r <= 1'b0;
      pa_en_r <= 1'b0;
    end else begin
      aerr_r <= aerr_nxt;
      perr_r <= perr_nxt;
      bist_r <= bist_nxt;
      flag_r <= perr_nxt | bist_nxt | aerr_nxt;
      valid_r <= char_tick;
      pa_en_r <= pa_en;
    end
  end

  // Register slave
  assign wr_status = reg_wr && (reg_addr == `STPIC_OFF_STATUS);
  assign wr_mask = reg_wr && (reg_addr == `STPIC_OFF_MASK);
  assign wr_ctrl = reg_wr && (reg_addr == `STPIC_OFF_CTRL);
  assign ev_set = {(aerr_nxt & ~aerr_r), bist_pass, par_bad};
  // Set wins over a write-one clear in the same cycle
  assign status_nxt = (status_r & ~(wr_status ? reg_wdata[11:0] : 12'h000)) | ev_set;
  assign rdata_nxt =
    (reg_addr == `STPIC_OFF_STATUS) ? {20'h0_0000, status_r} :
    (reg_addr == `STPIC_OFF_MASK) ? {20'h0_0000, mask_r} :
    (reg_addr == `STPIC_OFF_CTRL) ? {28'h000_0000, ctrl_r} :
    (reg_addr == `STPIC_OFF_STATE) ? {16'h0000, 7'h00, pa_en_r, aerr_r, flag_r} :
    32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_r <= '0;
      mask_r <= `STPIC_RST_MASK;
      ctrl_r <= `STPIC_RST_CTRL;
      rdata_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (wr_mask) mask_r <= reg_wdata[11:0];
      if (wr_ctrl) ctrl_r <= reg_wdata[NCH-1:0];
      rdata_r <= reg_rd ? rdata_nxt : 32'h0000_0000;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign tx_char_out = out_r;
  assign tx_char_valid = valid_r;
  assign tx_error_flag = flag_r;
  assign tx_phase_align_en = pa_en_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_parity_flag_pulse: assert property (
    par_bad[0] |=> tx_error_flag[0] && perr_r[0])
    else $error("parity error did not raise flag");
  chk_bad_char_sent: assert property (
    par_bad[0] |=> tx_char_out[0] == `STPIC_BAD_CHAR)
    else $error("bad character not substituted");
  chk_good_char_pass: assert property (
    (char_tick && !par_bad[2]) |=> tx_char_out[2] == $past(in_reg_r[2]))
    else $error("captured character not passed to shifter");
  chk_bist_pass_count: assert property (
    (ctrl_r[0] && char_tick && bist_cnt_r[0] == `STPIC_BIST_LAST) |=>
      tx_error_flag[0] && bist_cnt_r[0] == 9'h000)
    else $error("BIST pass not flagged at end of sequence");
  chk_pa_enable_mode: assert property (
    tx_phase_align_en == $past(csel_s != STPIC_SEL_LOW || rate_s))
    else $error("phase-align enable wrong");
  chk_align_err_hold: assert property (
    (aerr_r[3] && arst_n_s && !wsync_s[3]) |=> aerr_r[3] && tx_error_flag[3])
    else $error("align error dropped early");
  chk_ref_capture_all: assert property (
    (csel_s == STPIC_SEL_LOW && ref_rise) |-> &cap_stb)
    else $error("reference edge did not capture all channels");
  chk_chan_a_capture: assert property (
    (csel_s == STPIC_SEL_HIGH && chclk_rise[0]) |-> &cap_stb)
    else $error("channel A clock did not capture all channels");
  chk_parity_odd_good: assert property (
    (char_tick && par_en && ^{in_reg_r[1], in_par_r[1]}) |=>
      !perr_r[1] && tx_char_out[1] == $past(in_reg_r[1]))
    else $error("odd parity flagged as bad");
endmodule

// *** stpic_host_model.sv ***
module stpic_host_model (
  output logic reference_clock_in,
  output logic [3:0] tx_channel_input_clock,
  output logic [3:0][9:0] tx_char_in,
  output logic [3:0] tx_odd_parity_in,
  input wire logic [3:0][9:0] char_val,
  input wire logic [3:0] bad_par,
  input wire logic [3:0] stop_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // Reference runs free, 48 ns period
  initial begin
    reference_clock_in = 1'b0;
    forever #24 reference_clock_in = ~reference_clock_in;
  end
  // A stopped channel clock models a dead source on that channel
  assign tx_channel_input_clock = {4{reference_clock_in}} & ~stop_clk;
  initial begin
    tx_char_in = '0;
    tx_odd_parity_in = 4'hf;
  end
  always @(negedge reference_clock_in) begin
    for (int i = 0; i < 4; i++) begin
      tx_char_in[i] <= char_val[i];
      tx_odd_parity_in[i] <= ~(^char_val[i]) ^ bad_par[i];
    end
  end
endmodule

// *** stpic_top_test.sv ***
`include "stpic_defs.svh"
module stpic_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import stpic_pkg::*;
  logic core_clk, reset, reg_wr, reg_rd, tx_rate_select, tx_align_reset_n, irq;
  logic reference_clock_in, tx_phase_align_en, tx_char_clock_out, tx_char_clock_out_n;
  logic tx_char_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [3:0] tx_channel_input_clock, tx_odd_parity_in, tx_word_sync_in, tx_error_flag;
  logic [3:0] bad_par, stop_clk;
  logic [3:0][9:0] tx_char_in, tx_char_out, char_val;
  stpic_sel_t parity_control, tx_input_clock_select;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  stpic_top dut_u (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reference_clock_in, .tx_channel_input_clock, .tx_char_in, .tx_odd_parity_in,
    .parity_control, .tx_input_clock_select, .tx_rate_select, .tx_align_reset_n,
    .tx_word_sync_in, .tx_char_out, .tx_char_valid, .tx_error_flag, .tx_phase_align_en,
    .tx_char_clock_out, .tx_char_clock_out_n, .irq);
  stpic_host_model host_u (.reference_clock_in, .tx_channel_input_clock, .tx_char_in,
    .tx_odd_parity_in, .char_val, .bad_par, .stop_clk);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd_t(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  // Bounded wait for n character strobes, left just after the last one
  task automatic wait_valid(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        cyc(1);
        k++;
      end while (tx_char_valid !== 1'b1 && k < 40);
      if (k >= 40) check(0, 1, "no char strobe");
    end
  endtask

  // Word sync (m=1) or align reset (m=0) held for three cycles
  task automatic clear_align(input int m);
    @(posedge core_clk);
    if (m == 1) tx_word_sync_in <= 4'hf;
    else tx_align_reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    tx_word_sync_in <= 4'h0;
    tx_align_reset_n <= 1'b1;
  endtask

  task automatic t_reset;
    cyc(6);
    reg_rd_t(`STPIC_OFF_MASK);
    check(rd, 0, "mask reset");
    reg_rd_t(`STPIC_OFF_CTRL);
    check(rd, 0, "ctrl reset");
    reg_rd_t(8'h10);
    check(rd, 0, "unmapped read");
    reg_rd_t(`STPIC_OFF_STATE);
    check(rd, 0, "state reset");
  endtask

  task automatic t_chars;
    logic [9:0] v [4] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa};
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 4; i++) char_val[i] = v[(i + r) % 4];
      wait_valid(2);
      for (int i = 0; i < 4; i++) check(tx_char_out[i], v[(i + r) % 4], "char");
      check(tx_error_flag, 0, "good parity flag");
    end
  endtask

  // Character clock rises counted over ten reference periods
  task automatic t_clock(input int n);
    int rises = 0;
    int bad = 0;
    logic prev;
    wait_valid(1);
    cyc(60 / n);
    prev = tx_char_clock_out;
    repeat (120) begin
      cyc(1);
      if (tx_char_clock_out === 1'b1 && prev === 1'b0) rises++;
      if (tx_char_clock_out_n !== ~tx_char_clock_out) bad++;
      prev = tx_char_clock_out;
    end
    check(rises, n, "clock rises");
    check(bad, 0, "clock complement");
  endtask

  task automatic t_parity(input stpic_sel_t pc);
    logic on;
    int hi = 0;
    on = (pc != STPIC_SEL_LOW);
    @(posedge core_clk);
    parity_control <= pc;
    char_val[0] = 10'h155;
    char_val[1] = 10'h0f0;
    bad_par = 4'h1;
    wait_valid(2);
    check(tx_char_out[0], on ? 10'h278 : 10'h155, "bad char");
    check(tx_char_out[1], 10'h0f0, "neighbour char");
    bad_par = 4'h0;
    repeat (40) begin
      if (tx_error_flag[0] === 1'b1) hi++;
      cyc(1);
    end
    check(hi, on ? 12 : 0, "parity flag width");
    reg_rd_t(`STPIC_OFF_STATUS);
    check(rd, {31'h0, on}, "parity status");
    check(irq, 0, "masked irq");
    reg_wr_t(`STPIC_OFF_MASK, 32'h0000_000f);
    cyc(2);
    check(irq, on, "unmasked irq");
    reg_wr_t(`STPIC_OFF_STATUS, 32'h0000_0fff);
    cyc(2);
    check(irq, 0, "cleared irq");
    reg_wr_t(`STPIC_OFF_MASK, 32'h0000_0000);
  endtask

  task automatic t_bist;
    int k = 0;
    reg_wr_t(`STPIC_OFF_CTRL, 32'h0000_0001);
    reg_rd_t(`STPIC_OFF_CTRL);
    check(rd, 1, "ctrl readback");
    while (tx_error_flag[0] !== 1'b1 && k < 7000) begin
      cyc(1);
      k++;
    end
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (tx_error_flag[0] === 1'b1 && k < 20);
    check(k, 12, "pass pulse width");
    while (tx_error_flag[0] !== 1'b1 && k < 7000) begin
      cyc(1);
      k++;
    end
    check(k, 511 * 12, "pass interval");
    check(tx_error_flag[3:1], 0, "other channels");
    reg_rd_t(`STPIC_OFF_STATUS);
    check(rd[7:4], 4'h1, "bist status");
    reg_wr_t(`STPIC_OFF_CTRL, 32'h0000_0000);
    reg_wr_t(`STPIC_OFF_STATUS, 32'h0000_0fff);
  endtask

  task automatic t_align;
    @(posedge core_clk);
    tx_input_clock_select <= STPIC_SEL_HIGH;
    stop_clk = 4'he;
    char_val[1] = 10'h2c3;
    clear_align(0);
    wait_valid(4);
    check(tx_phase_align_en, 1, "align enable");
    check(tx_error_flag, 0, "shared clock flags");
    check(tx_char_out[1], 10'h2c3, "char on channel A clock");
    @(posedge core_clk);
    tx_input_clock_select <= STPIC_SEL_MID;
    clear_align(0);
    wait_valid(4);
    check(tx_error_flag, 4'he, "own clock underflow");
    reg_rd_t(`STPIC_OFF_STATUS);
    check(rd[11:8], 4'he, "align status");
    for (int m = 1; m >= 0; m--) begin
      stop_clk = 4'h0;
      wait_valid(3);
      check(tx_error_flag, 4'he, "align flag held");
      clear_align(m);
      wait_valid(2);
      check(tx_error_flag, 0, "align flag cleared");
      stop_clk = 4'he;
      wait_valid(4);
    end
    stop_clk = 4'h0;
    @(posedge core_clk);
    tx_input_clock_select <= STPIC_SEL_LOW;
    // Half rate only with select LOW
    tx_rate_select <= 1'b1;
    clear_align(0);
    wait_valid(4);
    check(tx_phase_align_en, 1, "half rate align enable");
    t_clock(20);
    @(posedge core_clk);
    tx_rate_select <= 1'b0;
    wait_valid(4);
    check(tx_phase_align_en, 0, "align disabled");
  endtask

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    parity_control = STPIC_SEL_MID;
    tx_input_clock_select = STPIC_SEL_LOW;
    tx_rate_select = 1'b0;
    tx_align_reset_n = 1'b1;
    tx_word_sync_in = 4'h0;
    char_val = '0;
    bad_par = 4'h0;
    stop_clk = 4'h0;
    cyc(8);
    check(tx_char_clock_out_n, 1, "clock out n in reset");
    @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_chars();
    t_clock(10);
    t_parity(STPIC_SEL_MID);
    t_parity(STPIC_SEL_HIGH);
    t_parity(STPIC_SEL_LOW);
    t_bist();
    t_align();
    print_verdict();
  end
endmodule
